/* hdl/chmc_pkg.sv */
// Package: register map, field positions, reset values and cycle counts of the channel main control
package chmc_pkg;

  // Register offsets on the 16-bit parallel port
  localparam logic [7:0]  CHMC_GAIN_OFS  = 8'h0B;
  localparam logic [7:0]  CHMC_CTRL_OFS  = 8'h0C;
  localparam logic [7:0]  CHMC_STAT_OFS  = 8'h10;

  // Reset values and writable masks
  localparam logic [15:0] CHMC_GAIN_RST  = 16'h0000;
  localparam logic [15:0] CHMC_CTRL_RST  = 16'h0000;
  localparam logic [15:0] CHMC_GAIN_MASK = 16'h01FF;

  // Gain ramp setup fields
  localparam int GB_BYPASS   = 8;
  localparam int GB_SHORT    = 7;
  localparam int GB_LEN_HI   = 6;

  // Main control fields
  localparam int CB_IMM      = 15;
  localparam int CB_GHOLD    = 14;
  localparam int CB_DELAY    = 13;
  localparam int CB_CHOLD    = 12;
  localparam int CB_TXINT    = 11;
  localparam int CB_AE_HI    = 10;
  localparam int CB_AE_LO    = 8;
  localparam int CB_CPLX     = 7;
  localparam int CB_ONLINE   = 6;
  localparam int CB_INEN     = 5;
  localparam int CB_OUTEN    = 4;
  localparam int CB_SIBFREE  = 3;
  localparam int CB_NOFLUSH  = 2;
  localparam int CB_NOOVR    = 1;
  localparam int CB_SWTX     = 0;

  // Status fields
  localparam int SB_DRAINED  = 8;
  localparam int SB_AEMPTY   = 9;
  localparam int SB_TXEN     = 10;

  // Cycle counts at the output sample clock
  localparam int IMM_SYNC_CYC = 4;
  localparam int MEM_FLUSH_CYC = 16;
  localparam int DRAIN_CYC    = 24;
  localparam int LAT_SHORTEN  = 2;

endpackage

/* hdl/chmc_fifo_if.sv */
// Interface: fill, drain and control signals between the control block and its input FIFO
`timescale 1ns/1ps
interface chmc_fifo_if #(
  parameter int W  = 32,
  parameter int CW = 5
);
  logic          wr_valid;
  logic          wr_ready;
  logic [W-1:0]  wr_data;
  logic          rd_valid;
  logic          rd_ready;
  logic [W-1:0]  rd_data;
  logic          flush;
  logic [CW-1:0] count;

  modport ctl (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data, count);
  modport mem (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data, count);
endinterface

/* hdl/chmc_fifo.sv */
// Module: synchronous I/Q input FIFO with flush and occupancy count
`timescale 1ns/1ps
module chmc_fifo
  import chmc_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // FIFO port
  chmc_fifo_if.mem f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           wr_fire;
  wire           rd_fire;

  assign f.wr_ready = (cnt_q != (AW+1)'(DEPTH)) && !f.flush;
  assign f.rd_valid = (cnt_q != '0) && !f.flush;
  assign f.rd_data  = mem_q[rp_q];
  assign f.count    = cnt_q;
  assign wr_fire    = f.wr_valid && f.wr_ready;
  assign rd_fire    = f.rd_ready && f.rd_valid;

  // Flush forces both pointers back to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (f.flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_fire) wp_q <= wp_q + AW'(1);
      if (rd_fire) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_fire) mem_q[wp_q] <= f.wr_data;
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n) cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

/* hdl/chmc_top.sv */
// Module: per-channel gain ramp setup and main control registers with the logic they steer
// Notes on behaviour
// (RULE1) Latency bit 7 shortens the transmit-enable delay path by two stages.
// (RULE2) Latency bit 8 bypasses alignment and feeds the raw pin enable to the channel.
// (RULE3) Host should pair shortened latency with data span 3 and interpolation code 4.
// (RULE4) Length field 6:0 is the highest gain ramp address visited.
// (RULE5) Bit 15 clear: masked updates; set: low word write loads shadow after 4 clocks.
// (RULE6) Bit 14 freezes the ramp and gives host the gain memory; clearing resumes.
// (RULE7) Host should reload gain profile only after the ramp has finished.
// (RULE8) Bit 13 inserts half coarse sample delay after the shaping filter.
// (RULE9) Bit 12 hands I and Q coefficient memories to the host.
// (RULE10) Bit 11 selects internal transmit enable, otherwise the external pin.
// (RULE11) Almost-empty flag at occupancy threshold bits 10:8 plus one, shared by I and Q.
// (RULE12) Bit 7 selects imaginary sums on channels 0 and 2 in real output mode.
// (RULE13) Bit 6 clear zeroes FIFO output; after 24 clocks channel drained flag rises.
// (RULE14) Hardware enable and update inputs are accepted only while bit 5 is set; with latency bit 8 set the pin enable passes regardless of bit 5.
// (RULE15) Bit 4 clear forces channel output to zero; set passes data.
// (RULE16) Bit 3 set keeps the serial block running regardless of transmit enable.
// (RULE17) With serial gating off the source should send zeros while enable is low.
// (RULE18) Rising transmit enable flushes channel and filter memory unless bit 2 set.
// (RULE19) In parallel mode FIFO overflow resets the channel unless bit 1 set.
// (RULE20) Rising software enable bit 0 flushes filter memory 16 clocks, masked update.
// (RULE21) Software enable high permits serial requests; low stops new frame strobes.
// (RULE22) Immediate mode: low word write of multi-word setting makes the shadow load strobe.
// (RULE23) Each update mask bit set lets its shadow group load; clear blocks it.
// (RULE24) Both registers are 16 bits; undocumented bits read zero and ignore writes.
`timescale 1ns/1ps
module chmc_top
  import chmc_pkg::*;
#(
  parameter int CH_IDX     = 0,
  parameter int DW         = 20,
  parameter int FW         = 32,
  parameter int FDEPTH     = 16,
  parameter int LAT_STAGES = 4
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // Host parallel port
  input  wire logic [7:0]    host_addr,
  input  wire logic [15:0]   host_wdata,
  input  wire logic          host_wr,
  input  wire logic          host_rd,
  output logic      [15:0]   host_rdata,
  input  wire logic          low_word_wr,
  input  wire logic [15:0]   shadow_sel,
  input  wire logic [15:0]   update_mask,
  output logic      [15:0]   shadow_load,
  // Transmit enable and update sources
  input  wire logic          transmit_gate_line,
  input  wire logic          hw_update_pin,
  input  wire logic          int_txen,
  output logic               chan_txen,
  output logic               chan_flush,
  output logic               mem_flush,
  output logic               chan_reset,
  // Serial interface block
  input  wire logic          frame_tick,
  output logic               serial_req_en,
  output logic               sib_run,
  output logic               tx_frame,
  // Sample input path
  input  wire logic          par_mode,
  input  wire logic          in_valid,
  input  wire logic [FW-1:0] in_data,
  output logic               in_ready,
  input  wire logic          sample_en,
  output logic      [FW-1:0] fifo_sample,
  output logic               almost_empty,
  output logic               drain_done_flag,
  // Gain ramp and memory ownership
  input  wire logic          ramp_tick,
  output logic      [6:0]    gain_addr,
  output logic               gain_host_sel,
  output logic               coef_host_sel,
  // Channel output path
  input  wire logic [DW-1:0] real_partial_two,
  input  wire logic [DW-1:0] imag_partial_one,
  input  wire logic          half_coarse_en,
  output logic      [DW-1:0] chan_out
);
  localparam int CW = $clog2(FDEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] gain_q;
  logic [15:0] ctrl_q;
  logic [15:0] rdata_q;
  wire         wr_gain   = host_wr && (host_addr == CHMC_GAIN_OFS);
  wire         wr_ctrl   = host_wr && (host_addr == CHMC_CTRL_OFS);
  wire  [15:0] stat_word;
  wire  [15:0] rd_mux    = (host_addr == CHMC_GAIN_OFS) ? gain_q :
                           (host_addr == CHMC_CTRL_OFS) ? ctrl_q :
                           (host_addr == CHMC_STAT_OFS) ? stat_word : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q  <= CHMC_GAIN_RST;
      ctrl_q  <= CHMC_CTRL_RST;
      rdata_q <= 16'h0000;
    end else begin
      if (wr_gain) gain_q <= host_wdata & CHMC_GAIN_MASK; // RULE24
      if (wr_ctrl) ctrl_q <= host_wdata;
      if (host_rd) rdata_q <= rd_mux;
    end
  end
  assign host_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic pin_s1_q, pin_s2_q, upd_s1_q, upd_s2_q, upd_prev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pin_s1_q, pin_s2_q, upd_s1_q, upd_s2_q, upd_prev_q} <= 5'h00;
    end else begin
      {pin_s1_q, pin_s2_q} <= {transmit_gate_line, pin_s1_q};
      {upd_s1_q, upd_s2_q} <= {hw_update_pin, upd_s1_q};
      upd_prev_q <= upd_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit enable selection and latency alignment
  logic [LAT_STAGES-1:0] lat_q;
  logic                  txen_q, txen_prev_q, swtx_prev_q;
  wire hw_tx    = ctrl_q[CB_TXINT] ? int_txen : pin_s2_q;   // RULE10
  wire hw_tx_ok = hw_tx && ctrl_q[CB_INEN];                 // RULE14
  wire lat_tap  = gain_q[GB_SHORT] ? lat_q[LAT_STAGES-1-LAT_SHORTEN] : lat_q[LAT_STAGES-1]; // RULE1
  wire txen_d   = gain_q[GB_BYPASS] ? pin_s2_q : lat_tap;   // RULE2
  wire tx_rise  = txen_q && !txen_prev_q;
  wire sw_rise  = ctrl_q[CB_SWTX] && !swtx_prev_q;
  wire upd_ev   = upd_s2_q && !upd_prev_q && ctrl_q[CB_INEN]; // RULE14
  wire hw_flush = tx_rise && !ctrl_q[CB_NOFLUSH];           // RULE18

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q       <= '0;
      txen_q      <= 1'b0;
      txen_prev_q <= 1'b0;
      swtx_prev_q <= 1'b0;
    end else begin
      lat_q       <= {lat_q[LAT_STAGES-2:0], hw_tx_ok};
      txen_q      <= txen_d;
      txen_prev_q <= txen_q;
      swtx_prev_q <= ctrl_q[CB_SWTX];
    end
  end
  assign chan_txen = txen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Flushing and shadow updates
  logic [4:0]              fcnt_q;
  logic                    cflush_q;
  logic [IMM_SYNC_CYC-1:0] imm_pipe_q;
  logic [15:0]             imm_sel_q;
  logic [15:0]             load_q;
  wire  [15:0]             mask_ld = (sw_rise || upd_ev) ? update_mask : 16'h0000;            // RULE23
  wire  [15:0]             imm_ld  = imm_pipe_q[IMM_SYNC_CYC-1] ? imm_sel_q : 16'h0000;       // RULE5
  wire                     imm_wr  = low_word_wr && ctrl_q[CB_IMM];                           // RULE22

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_q     <= 5'h00;
      cflush_q   <= 1'b0;
      imm_pipe_q <= '0;
      imm_sel_q  <= 16'h0000;
      load_q     <= 16'h0000;
    end else begin
      if (sw_rise || hw_flush) fcnt_q <= 5'(MEM_FLUSH_CYC); // RULE20
      else if (fcnt_q != 5'h00) fcnt_q <= fcnt_q - 5'h01;
      cflush_q   <= hw_flush;                               // RULE18
      imm_pipe_q <= {imm_pipe_q[IMM_SYNC_CYC-2:0], imm_wr};
      if (imm_wr) imm_sel_q <= shadow_sel;
      load_q     <= mask_ld | imm_ld;                       // RULE5
    end
  end
  assign mem_flush   = (fcnt_q != 5'h00);
  assign chan_flush  = cflush_q;
  assign shadow_load = load_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial interface gating
  assign serial_req_en = ctrl_q[CB_SWTX];                     // RULE21
  assign sib_run       = ctrl_q[CB_SIBFREE] || txen_q;        // RULE16
  assign tx_frame      = frame_tick && ctrl_q[CB_SWTX] && sib_run; // RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Input FIFO, offline drain and overflow reset
  chmc_fifo_if #(.W(FW), .CW(CW)) fif ();
  logic [FW-1:0] samp_q;
  logic [4:0]    dcnt_q;
  logic          ae_q, creset_q;
  wire           online  = ctrl_q[CB_ONLINE];
  // Not-ready caused by a flush is no overflow
  wire           ovf     = par_mode && in_valid && !fif.wr_ready && !fif.flush;
  wire           ovf_rst = ovf && !ctrl_q[CB_NOOVR];           // RULE19
  wire [CW-1:0]  ae_lvl  = CW'(ctrl_q[CB_AE_HI:CB_AE_LO]) + CW'(1);

  assign fif.wr_valid = in_valid;
  assign fif.wr_data  = in_data;
  assign fif.rd_ready = online && sample_en;
  assign fif.flush    = !online || creset_q;                   // RULE13
  assign in_ready     = fif.wr_ready;

  chmc_fifo #(.W(FW), .DEPTH(FDEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .f       (fif)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q   <= '0;
      dcnt_q   <= 5'h00;
      ae_q     <= 1'b1;
      creset_q <= 1'b0;
    end else begin
      if (!online) samp_q <= '0;                               // RULE13
      else if (sample_en) samp_q <= fif.rd_valid ? fif.rd_data : '0;
      if (online) dcnt_q <= 5'h00;
      else if (dcnt_q != 5'(DRAIN_CYC)) dcnt_q <= dcnt_q + 5'h01; // RULE13
      ae_q     <= (fif.count <= ae_lvl);                       // RULE11
      creset_q <= ovf_rst;
    end
  end
  assign fifo_sample     = samp_q;
  assign almost_empty    = ae_q;
  assign drain_done_flag = !online && (dcnt_q == 5'(DRAIN_CYC));
  assign chan_reset      = creset_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gain ramp and memory ownership
  logic [6:0] gaddr_q;
  wire  [6:0] glen    = gain_q[GB_LEN_HI:0];
  wire        ghold   = ctrl_q[CB_GHOLD];
  wire        ramp_up = txen_q && (gaddr_q < glen);            // RULE4
  wire        ramp_dn = !txen_q && (gaddr_q != 7'h00);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gaddr_q <= 7'h00;
    else if (!ghold && ramp_tick) begin                        // RULE6
      if (ramp_up) gaddr_q <= gaddr_q + 7'h01;
      else if (ramp_dn) gaddr_q <= gaddr_q - 7'h01;
      else if (gaddr_q > glen) gaddr_q <= glen;                // RULE4
    end
  end
  assign gain_addr     = gaddr_q;
  assign gain_host_sel = ghold;                                // RULE6
  assign coef_host_sel = ctrl_q[CB_CHOLD];                     // RULE9

  ////////////////////////////////////////////////////////////////////////////
  // Channel output path
  logic [DW-1:0] dly_q, out_q;
  wire           cplx_ch = (CH_IDX == 0) || (CH_IDX == 2);
  wire [DW-1:0]  osel    = (cplx_ch && ctrl_q[CB_CPLX]) ? imag_partial_one : real_partial_two; // RULE12
  wire [DW-1:0]  opath   = ctrl_q[CB_DELAY] ? dly_q : osel;   // RULE8

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= '0;
      out_q <= '0;
    end else begin
      if (half_coarse_en) dly_q <= osel;
      out_q <= ctrl_q[CB_OUTEN] ? opath : '0;                  // RULE15
    end
  end
  assign chan_out = out_q;

  assign stat_word = {5'h00, txen_q, ae_q, drain_done_flag, 1'b0, gaddr_q};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  gain_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n) gain_q[15:9] == 7'h00) // RULE24
    else $error("gain setup upper bits not zero");
  out_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE15
    !$past(ctrl_q[CB_OUTEN]) |-> chan_out == '0)
    else $error("output not zero while disabled");
  drain_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE13
    $fell(online) |-> !drain_done_flag [*8] ##[16:17] drain_done_flag)
    else $error("drain flag timing wrong");
  mem_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE20
    sw_rise |=> mem_flush [*8] ##1 mem_flush [*8] ##1 (!mem_flush || $past(sw_rise || hw_flush)))
    else $error("filter memory flush not 16 clocks");
  imm_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
    imm_wr |-> ##5 (shadow_load & $past(shadow_sel, 5)) == $past(shadow_sel, 5))
    else $error("immediate load missing after sync");
  mask_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE23
    (sw_rise && !imm_pipe_q[IMM_SYNC_CYC-1]) |=> shadow_load == $past(update_mask))
    else $error("masked update wrong");
  frame_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) !ctrl_q[CB_SWTX] |-> !tx_frame) // RULE21
    else $error("frame strobe while software enable low");
  flush_sup_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE18
    (tx_rise && ctrl_q[CB_NOFLUSH]) |=> !chan_flush)
    else $error("flush not suppressed");
  ovf_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE19
    (ovf && !ctrl_q[CB_NOOVR]) |=> chan_reset ##1 fif.count == '0)
    else $error("overflow did not reset channel");
  ramp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) ghold |=> $stable(gaddr_q)) // RULE6
    else $error("ramp moved while held");
  lat_short_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    (gain_q[GB_SHORT] && !gain_q[GB_BYPASS] && $stable(gain_q)) |=> txen_q == $past(lat_q[LAT_STAGES-1-LAT_SHORTEN]))
    else $error("shortened latency tap wrong");
  ae_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE11
    almost_empty == ($past(fif.count) <= CW'($past(ctrl_q[CB_AE_HI:CB_AE_LO])) + CW'(1)))
    else $error("almost empty flag wrong");

  drain_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(drain_done_flag));
  imm_c:   cover property (@(posedge sys_clk) disable iff (!rst_n) imm_wr ##5 shadow_load != 16'h0000);
  ramp_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) ramp_tick && gaddr_q == glen && glen != 7'h00);
  full_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) !fif.wr_ready && online);
endmodule

/* test/chmc_src_model.sv */
// Partner model: baseband sample source feeding the channel input FIFO
`timescale 1ns/1ps
module chmc_src_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        src_en,
  input  wire logic        gate_off,
  input  wire logic        txen,
  // FIFO fill side
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic      [31:0] in_data
);
  logic [15:0] seq_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) seq_q <= 16'h0000;
    else if (in_valid && in_ready) seq_q <= seq_q + 16'h0001;
  end
  assign in_valid = src_en;
  // Idle bus shows FFFF over the inverted sequence count; zeros while gate is off and enable low
  assign in_data = !in_valid ? {16'hFFFF, ~seq_q} : (gate_off && !txen) ? 32'h0 : {16'hA500, seq_q};
endmodule

/* test/tb_chmc_top.sv */
// Testbench: self-checking scenarios for the channel main control
`timescale 1ns/1ps
module tb_chmc_top;
  import chmc_pkg::*;
  logic        sys_clk, rst_n, host_wr, host_rd, low_word_wr, transmit_gate_line, hw_update_pin;
  logic        int_txen, chan_txen, chan_flush, mem_flush, chan_reset, frame_tick, serial_req_en;
  logic        sib_run, tx_frame, par_mode, in_valid, in_ready, sample_en, almost_empty;
  logic        drain_done_flag, ramp_tick, gain_host_sel, coef_host_sel, src_en, half_coarse_en;
  logic [7:0]  host_addr;
  logic [6:0]  gain_addr;
  logic [15:0] host_wdata, host_rdata, shadow_sel, update_mask, shadow_load;
  logic [31:0] in_data, fifo_sample;
  logic [19:0] real_partial_two, imag_partial_one, chan_out;
  int          n_fail, num_checks;
  localparam int FDEPTH_TB = 16;

  chmc_top DUT (.sys_clk, .rst_n, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .low_word_wr, .shadow_sel, .update_mask, .shadow_load, .transmit_gate_line, .hw_update_pin,
    .int_txen, .chan_txen, .chan_flush, .mem_flush, .chan_reset, .frame_tick, .serial_req_en,
    .sib_run, .tx_frame, .par_mode, .in_valid, .in_data, .in_ready, .sample_en, .fifo_sample,
    .almost_empty, .drain_done_flag, .ramp_tick, .gain_addr, .gain_host_sel, .coef_host_sel,
    .real_partial_two, .imag_partial_one, .half_coarse_en, .chan_out);
  chmc_src_model SRC (.sys_clk, .rst_n, .src_en, .gate_off(1'b0), .txen(chan_txen), .in_ready,
    .in_valid, .in_data);

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    cyc(1);
    host_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] v);
    host_addr = a;
    host_rd = 1'b1;
    cyc(1);
    v = host_rdata;
    host_rd = 1'b0;
    cyc(1);
  endtask
  // Cycles until shadow_load shows e, lim if never
  task automatic seek(logic [15:0] e, int lim, output int n);
    n = 0;
    while (shadow_load !== e && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic pulse_lw();
    low_word_wr = 1'b1;
    cyc(1);
    low_word_wr = 1'b0;
  endtask
  task automatic tick(int n);
    repeat (n) begin
      ramp_tick = 1'b1;
      cyc(1);
      ramp_tick = 1'b0;
      cyc(1);
    end
  endtask
  // Raise the pin and measure the cycles to chan_txen
  task automatic lat(logic [15:0] g, logic [15:0] c, output int n, output logic fl);
    wr(CHMC_GAIN_OFS, g);
    wr(CHMC_CTRL_OFS, c);
    transmit_gate_line = 1'b1;
    n = 0;
    fl = 1'b0;
    while (chan_txen !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    repeat (3) begin
      cyc(1);
      fl = fl | chan_flush;
    end
    transmit_gate_line = 1'b0;
    cyc(20);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] v;
    rd(CHMC_GAIN_OFS, v);
    chk("gain reset", CHMC_GAIN_RST, v);
    rd(CHMC_CTRL_OFS, v);
    chk("ctrl reset", CHMC_CTRL_RST, v);
    wr(CHMC_GAIN_OFS, 16'hFFFF);
    rd(CHMC_GAIN_OFS, v);
    chk("gain mask", CHMC_GAIN_MASK, v);
    wr(CHMC_CTRL_OFS, 16'h5008);
    rd(CHMC_CTRL_OFS, v);
    chk("ctrl rw", 16'h5008, v);
    chk("owners", 3'b111, {gain_host_sel, coef_host_sel, sib_run});
    rd(8'h20, v);
    chk("unmapped", 16'h0000, v);
    wr(CHMC_CTRL_OFS, 16'h0000);
    chk("owners off", 3'b000, {gain_host_sel, coef_host_sel, sib_run});
  endtask

  task automatic t_sw();
    int n;
    update_mask = 16'h00A5;
    wr(CHMC_CTRL_OFS, 16'h0001);
    chk("sw load", 16'h00A5, shadow_load);
    n = 0;
    while (mem_flush === 1'b1 && n < 40) begin
      n++;
      cyc(1);
    end
    chk("flush len", MEM_FLUSH_CYC, n);
    wr(CHMC_CTRL_OFS, 16'h0009);
    frame_tick = 1'b1;
    cyc(1);
    chk("frame on", 2'b11, {serial_req_en, tx_frame});
    wr(CHMC_CTRL_OFS, 16'h0008);
    chk("frame off", 2'b00, {serial_req_en, tx_frame});
    frame_tick = 1'b0;
    update_mask = 16'h0000;
    wr(CHMC_CTRL_OFS, 16'h0009);
    repeat (4) begin
      cyc(1);
      chk("mask zero", 16'h0000, shadow_load);
    end
    wr(CHMC_CTRL_OFS, 16'h0000);
    update_mask = 16'h0003;
    hw_update_pin = 1'b1;
    seek(16'h0003, 8, n);
    chk("hw gated", 8, n);
    hw_update_pin = 1'b0;
    wr(CHMC_CTRL_OFS, 16'h0020);
    cyc(4);
    hw_update_pin = 1'b1;
    seek(16'h0003, 8, n);
    chk("hw update", 1, n < 8);
    hw_update_pin = 1'b0;
    wr(CHMC_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_imm();
    int n;
    update_mask = 16'h0000;
    shadow_sel = 16'h0040;
    pulse_lw();
    seek(16'h0040, 8, n);
    chk("imm off", 8, n);
    wr(CHMC_CTRL_OFS, 16'h8000);
    pulse_lw();
    seek(16'h0040, 8, n);
    chk("imm delay", IMM_SYNC_CYC, n);
    wr(CHMC_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_tx();
    int   a, b, c, d;
    logic f0, f1, f2;
    lat(16'h0000, 16'h0020, a, f0);
    lat(16'h0080, 16'h0024, b, f1);
    lat(16'h0100, 16'h0020, c, f2);
    chk("short path", a - LAT_SHORTEN, b);
    chk("bypass", 1, c < b);
    chk("rise flush", 2'b10, {f0, f1});
    lat(16'h0000, 16'h0000, d, f2);
    chk("pin gated", 20, d);
    lat(16'h0003, 16'h0820, d, f2);
    chk("pin unused", 20, d);
    int_txen = 1'b1;
    cyc(12);
    chk("int txen", 1, chan_txen);
    tick(6);
    chk("ramp top", 3, gain_addr);
    wr(CHMC_CTRL_OFS, 16'h4820);
    int_txen = 1'b0;
    cyc(12);
    tick(6);
    chk("ramp held", 3, gain_addr);
    wr(CHMC_CTRL_OFS, 16'h0820);
    tick(6);
    chk("ramp resume", 0, gain_addr);
    wr(CHMC_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_fifo();
    int          n;
    logic [15:0] v;
    wr(CHMC_CTRL_OFS, 16'h0142);
    par_mode = 1'b1;
    src_en = 1'b1;
    n = 0;
    while (in_ready !== 1'b0 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("fill", FDEPTH_TB, n);
    cyc(3);
    chk("no ovr reset", 0, chan_reset);
    chk("full ae", 0, almost_empty);
    src_en = 1'b0;
    for (int i = 0; i < FDEPTH_TB; i++) begin
      sample_en = 1'b1;
      cyc(1);
      sample_en = 1'b0;
      chk("pop", {16'hA500, 16'(i)}, fifo_sample);
      cyc(1);
      chk("ae level", (15 - i) <= 2, almost_empty);
    end
    wr(CHMC_CTRL_OFS, 16'h0140);
    src_en = 1'b1;
    n = 0;
    while (chan_reset !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("ovr reset", 1, n < 40);
    src_en = 1'b0;
    par_mode = 1'b0;
    wr(CHMC_CTRL_OFS, 16'h0000);
    n = 0;
    while (drain_done_flag !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("drain time", 1, n >= DRAIN_CYC - 1 && n <= DRAIN_CYC + 1);
    rd(CHMC_STAT_OFS, v);
    chk("status", (1 << SB_DRAINED) | (1 << SB_AEMPTY), v);
    sample_en = 1'b1;
    cyc(1);
    sample_en = 1'b0;
    chk("offline zero", 0, fifo_sample);
  endtask

  task automatic t_out();
    real_partial_two = 20'h12345;
    imag_partial_one = 20'hABCDE;
    cyc(2);
    chk("out off", 0, chan_out);
    wr(CHMC_CTRL_OFS, 16'h0010);
    cyc(2);
    chk("out real", 20'h12345, chan_out);
    wr(CHMC_CTRL_OFS, 16'h0090);
    cyc(2);
    chk("out imag", 20'hABCDE, chan_out);
    half_coarse_en = 1'b1;
    wr(CHMC_CTRL_OFS, 16'h2090);
    half_coarse_en = 1'b0;
    imag_partial_one = 20'h54321;
    cyc(2);
    chk("out delay", 20'hABCDE, chan_out);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, host_wr, host_rd, low_word_wr, transmit_gate_line, hw_update_pin} = '0;
    {int_txen, frame_tick, par_mode, sample_en, ramp_tick, src_en, half_coarse_en} = '0;
    {host_addr, host_wdata, shadow_sel, update_mask} = '0;
    {real_partial_two, imag_partial_one} = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    t_regs();
    t_sw();
    t_imm();
    t_tx();
    t_fifo();
    t_out();
    stop_test();
  end
endmodule
